// ===== pbo_edge_rst.sv
// Rising edge detector that turns a reset request into a held reset
`timescale 1ns/100ps
`default_nettype none
module pbo_edge_rst
    import pbo_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Synchronised request level
    input wire logic req_in,
    // Reset seen by the path, held while the request stands
    output logic rst_out,
    output logic edge_out
);
    typedef struct packed {
        logic prev;
        logic hold;
        logic edge_p;
    } pbo_edge_t;
    pbo_edge_t s_q;
    pbo_edge_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev = req_in;
        s_d.edge_p = req_in & ~s_q.prev;
        // Edge starts the reset; it stays until the request drops
        if (req_in & ~s_q.prev) begin
            s_d.hold = 1'b1;
        end else if (!req_in) begin
            s_d.hold = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rst_out = s_q.hold;
    assign edge_out = s_q.edge_p;
endmodule
`default_nettype wire

// ===== pbo_far_model.sv
// Far-side model: deserializer word source
`timescale 1ns/100ps
`default_nettype none
module pbo_far_model
    import pbo_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Deserializer held in reset by the lane
    input wire logic ana_rst_in,
    // Word to deliver
    input wire logic [PBO_DATA_W-1:0] word_in,
    output logic [PBO_DATA_W-1:0] rx_des_out
);
    // No valid word under reset: shows the inverse, so early sampling is caught
    always_comb begin
        rx_des_out = ana_rst_in ? ~word_in : word_in;
    end
endmodule
`default_nettype wire

// ===== pbo_lane.sv
// Lane bit order, byte order, polarity and reset stage
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - With TX bit reversal configured, reverse each TX word before the serializer.
// - RX bit reverse enable flips RX word order to MSB-first; synchronised first.
// - RX byte reverse enable swaps sub-words, for 8 or 10 bit sub-words.
// - With TX inversion enabled, TX polarity input inverts TX data.
// - With RX inversion enabled, RX polarity input inverts RX data.
// - With idle port enabled, idle input forces the transmitter to electrical idle.
// - Control ports exist even when their function is disabled.
// - PLL powerdown is active high, edge sensitive, resets the TX PLL.
// - TX analog reset resets TX analog, clock generation and serializer.
// - TX digital reset resets the TX datapath digital logic.
// - RX analog reset resets the CDR and deserializer.
// - RX digital reset resets the RX datapath digital logic.
module pbo_lane
    import pbo_pkg::*;
#(
    parameter int DATA_W = PBO_DATA_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Static configuration
    input wire logic cfg_tx_bitrev_in,
    input wire logic cfg_rx_bitrev_in,
    input wire logic cfg_rx_byterev_in,
    input wire logic cfg_tx_polinv_in,
    input wire logic cfg_rx_polinv_in,
    input wire logic cfg_tx_idle_in,
    input wire logic cfg_sub10_in,
    // Asynchronous controls from the fabric
    input wire logic rx_bitrev_en_in,
    input wire logic rx_byterev_en_in,
    input wire logic tx_polinv_in,
    input wire logic rx_polinv_in,
    input wire logic tx_idle_in,
    // Reset requests
    input wire logic pll_pwrdn_in,
    input wire logic tx_ana_rst_in,
    input wire logic tx_dig_rst_in,
    input wire logic rx_ana_rst_in,
    input wire logic rx_dig_rst_in,
    // TX data
    input wire logic [DATA_W-1:0] tx_data_in,
    output logic [DATA_W-1:0] tx_ser_out,
    output logic tx_idle_out,
    // RX data
    input wire logic [DATA_W-1:0] rx_des_in,
    output logic [DATA_W-1:0] rx_data_out,
    // Reset state seen by the analog section
    output logic pll_rst_out,
    output logic tx_ana_rst_out,
    output logic rx_ana_rst_out
);
    localparam int NSIG = 10;

    typedef struct packed {
        logic [DATA_W-1:0] tx_word;
        logic [DATA_W-1:0] rx_des;
        logic [DATA_W-1:0] rx_word;
        logic tx_idle;
        logic pll_rst;
        logic tx_ana_rst;
        logic rx_ana_rst;
    } pbo_state_t;
    pbo_state_t s_q;
    pbo_state_t s_d;

    logic [NSIG-1:0] raw;
    logic [NSIG-1:0] syn;
    logic tx_dig_rst;
    logic rx_dig_rst;
    logic pll_rst;
    logic tx_ana_rst;
    logic rx_ana_rst;
    logic pll_edge;
    logic tx_edge;
    logic rx_edge;

    function automatic logic [DATA_W-1:0] bit_rev(input logic [DATA_W-1:0] w);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W; i++) begin
            r[i] = w[DATA_W-1-i];
        end
        return r;
    endfunction

    // Sub-word swap; sub-word width chosen by configuration
    function automatic logic [DATA_W-1:0] byte_rev(input logic [DATA_W-1:0] w, input logic sub10);
        logic [DATA_W-1:0] r;
        int n;
        int sw;
        r = w;
        sw = sub10 ? PBO_SUB_W10 : PBO_SUB_W8;
        n = DATA_W / sw;
        for (int k = 0; k < DATA_W; k++) begin
            if (k < n * sw) begin
                r[k] = w[(n - 1 - k / sw) * sw + k % sw];
            end
        end
        return r;
    endfunction

    // All fabric controls are asynchronous, so every one is synchronised
    assign raw = {rx_bitrev_en_in, rx_byterev_en_in, tx_polinv_in, rx_polinv_in, tx_idle_in,
                  pll_pwrdn_in, tx_ana_rst_in, tx_dig_rst_in, rx_ana_rst_in, rx_dig_rst_in};

    genvar g;
    generate
        for (g = 0; g < NSIG; g++) begin : g_sync
            pbo_sync u_sync (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .d_in(raw[g]),
                .q_out(syn[g])
            );
        end
    endgenerate

    assign tx_dig_rst = syn[2];
    assign rx_dig_rst = syn[0];

    pbo_edge_rst u_pll (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .req_in(syn[4]),
        .rst_out(pll_rst),
        .edge_out(pll_edge)
    );

    pbo_edge_rst u_txa (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .req_in(syn[3]),
        .rst_out(tx_ana_rst),
        .edge_out(tx_edge)
    );

    pbo_edge_rst u_rxa (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .req_in(syn[1]),
        .rst_out(rx_ana_rst),
        .edge_out(rx_edge)
    );

    always_comb begin
        logic [DATA_W-1:0] t;
        logic [DATA_W-1:0] r;
        t = tx_data_in;
        r = s_q.rx_des;
        s_d = s_q;
        s_d.pll_rst = pll_rst;
        s_d.tx_ana_rst = tx_ana_rst;
        s_d.rx_ana_rst = rx_ana_rst;
        if (cfg_tx_bitrev_in) begin
            t = bit_rev(t);
        end
        // Enables gate the port; the port stays present when disabled
        if (cfg_tx_polinv_in && syn[7]) begin
            t = ~t;
        end
        if (cfg_rx_polinv_in && syn[6]) begin
            r = ~r;
        end
        if (cfg_rx_bitrev_in && syn[9]) begin
            r = bit_rev(r);
        end
        if (cfg_rx_byterev_in && syn[8]) begin
            r = byte_rev(r, cfg_sub10_in);
        end
        s_d.tx_idle = cfg_tx_idle_in & syn[5];
        // Idle or serializer reset sends nothing
        s_d.tx_word = (s_d.tx_idle || tx_ana_rst) ? '0 : t;
        // Deserializer words ignored until its reset output has dropped too
        s_d.rx_des = (rx_ana_rst || s_q.rx_ana_rst) ? '0 : rx_des_in;
        s_d.rx_word = r;
        if (tx_dig_rst) begin
            s_d.tx_word = '0;
        end
        if (rx_dig_rst) begin
            s_d.rx_des = '0;
            s_d.rx_word = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_ser_out = s_q.tx_word;
    assign tx_idle_out = s_q.tx_idle;
    assign rx_data_out = s_q.rx_word;
    assign pll_rst_out = s_q.pll_rst;
    assign tx_ana_rst_out = s_q.tx_ana_rst;
    assign rx_ana_rst_out = s_q.rx_ana_rst;

    a_tx_idle_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_idle_out |-> tx_ser_out == '0) else $error("idle not quiet");
    a_tx_inv_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (!cfg_tx_bitrev_in && cfg_tx_polinv_in && syn[7] && !tx_dig_rst && !tx_ana_rst && !s_d.tx_idle)
        |=> tx_ser_out == ~$past(tx_data_in)) else $error("tx inversion wrong");
    a_tx_rev_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_tx_bitrev_in && !(cfg_tx_polinv_in && syn[7]) && !tx_dig_rst && !tx_ana_rst && !s_d.tx_idle)
        |=> tx_ser_out == bit_rev($past(tx_data_in))) else $error("tx reversal wrong");
    a_tx_dig_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_dig_rst |=> tx_ser_out == '0) else $error("tx not reset");
    a_rx_dig_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_dig_rst |=> rx_data_out == '0) else $error("rx not reset");
    a_pll_edge_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        pll_edge |=> pll_rst_out) else $error("pll reset missed");
    // Checked one cycle on, so a single-cycle request pulse is covered too
    a_tx_ana_edge: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_edge |=> tx_ana_rst_out && tx_ser_out == '0) else $error("tx analog reset missed");
    a_rx_ana_edge: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_edge |=> rx_ana_rst_out) else $error("rx analog reset missed");
    a_rx_inv_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_rx_polinv_in && syn[6] && !(cfg_rx_bitrev_in && syn[9]) && !(cfg_rx_byterev_in && syn[8])
        && !rx_dig_rst) |=> rx_data_out == ~$past(s_q.rx_des)) else $error("rx inversion wrong");

    // Remaining RX orderings except inversion with byte swap alone, including the untouched word
    a_rx_rev_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_rx_bitrev_in && syn[9] && !(cfg_rx_polinv_in && syn[6]) && !(cfg_rx_byterev_in && syn[8])
        && !rx_dig_rst) |=> rx_data_out == bit_rev($past(s_q.rx_des)))
        else $error("rx reversal wrong");
    a_rx_swap_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_rx_byterev_in && syn[8] && !(cfg_rx_polinv_in && syn[6]) && !(cfg_rx_bitrev_in && syn[9])
        && !rx_dig_rst) |=> rx_data_out == byte_rev($past(s_q.rx_des), $past(cfg_sub10_in)))
        else $error("rx byte swap wrong");
    a_rx_pol_rev: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_rx_polinv_in && syn[6] && cfg_rx_bitrev_in && syn[9] && !(cfg_rx_byterev_in && syn[8])
        && !rx_dig_rst) |=> rx_data_out == bit_rev(~$past(s_q.rx_des)))
        else $error("rx invert and reverse wrong");
    a_rx_rev_swap: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_rx_bitrev_in && syn[9] && cfg_rx_byterev_in && syn[8] && !(cfg_rx_polinv_in && syn[6])
        && !rx_dig_rst) |=> rx_data_out == byte_rev(bit_rev($past(s_q.rx_des)), $past(cfg_sub10_in)))
        else $error("rx reverse and swap wrong");
    a_rx_all_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_rx_polinv_in && syn[6] && cfg_rx_bitrev_in && syn[9] && cfg_rx_byterev_in && syn[8]
        && !rx_dig_rst) |=> rx_data_out == byte_rev(bit_rev(~$past(s_q.rx_des)), $past(cfg_sub10_in)))
        else $error("rx full reorder wrong");
    a_rx_plain_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (!(cfg_rx_polinv_in && syn[6]) && !(cfg_rx_bitrev_in && syn[9]) && !(cfg_rx_byterev_in && syn[8])
        && !rx_dig_rst) |=> rx_data_out == $past(s_q.rx_des))
        else $error("rx word altered");

    // Data held quiet while a path reset stands
    a_rx_ana_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_ana_rst |=> s_q.rx_des == '0)
        else $error("rx word taken in reset");
    a_rx_ana_late: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_ana_rst_out |=> s_q.rx_des == '0)
        else $error("rx word taken before release");
    a_rx_dig_feed: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_dig_rst |=> s_q.rx_des == '0)
        else $error("rx input not reset");
    a_tx_ana_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_ana_rst |=> tx_ser_out == '0)
        else $error("tx sent in analog reset");

    // Remaining TX paths and the idle gate
    a_tx_plain_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (!cfg_tx_bitrev_in && !(cfg_tx_polinv_in && syn[7]) && !tx_dig_rst && !tx_ana_rst && !s_d.tx_idle)
        |=> tx_ser_out == $past(tx_data_in))
        else $error("tx word altered");
    a_tx_both_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_tx_bitrev_in && cfg_tx_polinv_in && syn[7] && !tx_dig_rst && !tx_ana_rst && !s_d.tx_idle)
        |=> tx_ser_out == ~bit_rev($past(tx_data_in)))
        else $error("tx reverse and invert wrong");
    a_tx_idle_set: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_tx_idle_in && syn[5]) |=> tx_idle_out)
        else $error("idle not forced");
    a_tx_idle_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        !cfg_tx_idle_in |=> !tx_idle_out)
        else $error("idle forced while disabled");

    // Reset outputs follow the synchronised request within two cycles
    a_pll_rise_seen: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(syn[4]) |-> ##2 pll_rst_out)
        else $error("pll reset late");
    a_pll_drop_seen: assert property (@(posedge clk_in) disable iff (rst_in)
        !syn[4] |-> ##2 !pll_rst_out)
        else $error("pll reset stuck");
    a_tx_ana_rise: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(syn[3]) |-> ##2 tx_ana_rst_out)
        else $error("tx analog reset late");
    a_tx_ana_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        !syn[3] |-> ##2 !tx_ana_rst_out)
        else $error("tx analog reset stuck");
    a_rx_ana_rise: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(syn[1]) |-> ##2 rx_ana_rst_out)
        else $error("rx analog reset late");
    a_rx_ana_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        !syn[1] |-> ##2 !rx_ana_rst_out)
        else $error("rx analog reset stuck");
endmodule
`default_nettype wire

// ===== pbo_pkg.sv
// Package of constants for the bit order, polarity and reset stage
package pbo_pkg;
    localparam int PBO_SUB_W8 = 8;
    localparam int PBO_SUB_W10 = 10;
    localparam int PBO_DATA_W = 20;
    localparam int PBO_SYNC_STAGES = 2;
    localparam logic PBO_CFG_RST = 1'b0;
endpackage

// ===== pbo_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module pbo_sync
    import pbo_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Level
    input wire logic d_in,
    output logic q_out
);
    typedef struct packed {
        logic meta;
        logic sync;
    } pbo_sync_t;
    pbo_sync_t s_q;
    pbo_sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = d_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_out = s_q.sync;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench for the lane bit order, polarity and reset stage
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pbo_pkg::*;
    localparam int W = PBO_DATA_W;
    localparam logic [W-1:0] A = 20'h3a5c1;
    localparam logic [W-1:0] B = 20'hc3961;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [6:0] cfg = 7'h00;
    logic [4:0] ctl = 5'h00;
    logic [4:0] rq = 5'h00;
    logic [W-1:0] tx_d = A;
    logic [W-1:0] rx_w = B;
    logic [W-1:0] rx_des;
    logic [W-1:0] tx_ser;
    logic [W-1:0] rx_data;
    logic tx_idle;
    logic pll_rst;
    logic tx_ana;
    logic rx_ana;
    int error_cnt = 0;
    int samples_checked = 0;

    always #4 clk_in = ~clk_in;

    pbo_far_model far (.clk_in(clk_in), .ana_rst_in(rx_ana), .word_in(rx_w), .rx_des_out(rx_des));

    pbo_lane #(.DATA_W(W)) dut (
        .clk_in(clk_in), .rst_in(rst_in),
        .cfg_tx_bitrev_in(cfg[0]), .cfg_rx_bitrev_in(cfg[1]), .cfg_rx_byterev_in(cfg[2]),
        .cfg_tx_polinv_in(cfg[3]), .cfg_rx_polinv_in(cfg[4]), .cfg_tx_idle_in(cfg[5]),
        .cfg_sub10_in(cfg[6]),
        .rx_bitrev_en_in(ctl[0]), .rx_byterev_en_in(ctl[1]), .tx_polinv_in(ctl[2]),
        .rx_polinv_in(ctl[3]), .tx_idle_in(ctl[4]),
        .pll_pwrdn_in(rq[0]), .tx_ana_rst_in(rq[1]), .tx_dig_rst_in(rq[2]),
        .rx_ana_rst_in(rq[3]), .rx_dig_rst_in(rq[4]),
        .tx_data_in(tx_d), .tx_ser_out(tx_ser), .tx_idle_out(tx_idle),
        .rx_des_in(rx_des), .rx_data_out(rx_data),
        .pll_rst_out(pll_rst), .tx_ana_rst_out(tx_ana), .rx_ana_rst_out(rx_ana)
    );

    function automatic logic [W-1:0] rev(input logic [W-1:0] x);
        for (int i = 0; i < W; i++) begin
            rev[i] = x[W-1-i];
        end
    endfunction

    // m: polarity, bit reverse, byte reverse, 10-bit sub-words
    function automatic logic [W-1:0] rx_exp(input logic [W-1:0] x, input logic [3:0] m);
        logic [W-1:0] y;
        int s;
        y = m[0] ? ~x : x;
        y = m[1] ? rev(y) : y;
        s = m[3] ? 10 : 8;
        rx_exp = y;
        for (int i = 0; i < s; i++) begin
            if (m[2]) begin
                rx_exp[i] = y[s+i];
                rx_exp[s+i] = y[i];
            end
        end
    endfunction

    task automatic chk(input logic [W-1:0] exp, input logic [W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Controls cross a synchroniser, so allow it and the data latency to settle
    task automatic set(input logic [6:0] c, input logic [4:0] k, input logic [4:0] r);
        @(posedge clk_in);
        cfg <= c;
        ctl <= k;
        rq <= r;
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    task automatic test_tx();
        logic [W-1:0] y;
        for (int m = 0; m < 8; m++) begin
            set({3'h0, m[1], 2'h0, m[0]}, {2'h0, m[2], 2'h0}, 5'h00);
            y = m[0] ? rev(A) : A;
            chk((m[1] && m[2]) ? ~y : y, tx_ser);
        end
        $display("test tx done");
    endtask

    // Words change once and are checked on each following cycle, so a stale or early word shows up here
    task automatic test_lat();
        set(7'h03, 5'h01, 5'h00);
        @(posedge clk_in);
        tx_d <= B;
        rx_w <= A;
        @(negedge clk_in);
        chk(rev(A), tx_ser);
        @(negedge clk_in);
        chk(rev(B), tx_ser);
        chk(rev(B), rx_data);
        @(negedge clk_in);
        chk(rev(A), rx_data);
        @(posedge clk_in);
        tx_d <= A;
        rx_w <= B;
        $display("test latency done");
    endtask

    task automatic test_rx();
        for (int m = 0; m < 16; m++) begin
            set({m[3], 6'h16}, {1'b0, m[0], 1'b0, m[2], m[1]}, 5'h00);
            chk(rx_exp(B, 4'(m)), rx_data);
        end
        set(7'h40, 5'h1f, 5'h00);
        chk(B, rx_data);
        chk(A, tx_ser);
        $display("test rx done");
    endtask

    task automatic test_idle();
        set(7'h20, 5'h10, 5'h00);
        chk(W'(1'b1), W'(tx_idle));
        chk(20'h00000, tx_ser);
        set(7'h20, 5'h00, 5'h00);
        chk(W'(1'b0), W'(tx_idle));
        chk(A, tx_ser);
        $display("test idle done");
    endtask

    task automatic test_rst();
        for (int i = 0; i < 5; i++) begin
            set(7'h00, 5'h00, 5'(1 << i));
            chk(W'({i == 0, i == 1, i == 3}), W'({pll_rst, tx_ana, rx_ana}));
            chk((i == 1 || i == 2) ? 20'h00000 : A, tx_ser);
            chk((i == 3 || i == 4) ? 20'h00000 : B, rx_data);
            set(7'h00, 5'h00, 5'h00);
            chk(W'(3'h0), W'({pll_rst, tx_ana, rx_ana}));
            chk(B, rx_data);
            chk(A, tx_ser);
        end
        $display("test reset done");
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        test_tx();
        test_lat();
        test_rx();
        test_idle();
        test_rst();
        end_sim();
    end
endmodule
`default_nettype wire
